// File: rtl/seq_regs.svh
/*
 Register map, instruction layout and field positions of the positioning program flow sequencer.
 Assumes a 32-bit program word store and a classic Wishbone master with byte addresses.
*/
// How it works
// - Pulse-wait holds until the accumulated pulse total exceeds its setting.
// - Pulse-wait with zero setting clears the accumulated pulse total instead.
// - Steps between loop-open and loop-close repeat as many times as the loop-open count.
// - Loop-open with zero setting repeats the enclosed steps endlessly.
// - Program-repeat at the first step runs the whole program that many program_repeat_cmd.
// - Without a program-repeat command the program runs exactly once.
// - Program-repeat with zero setting repeats the whole program endlessly.
// - Armed position latch captures current position when latch input switches on.
// - After position-latch the sequencer waits until the latch input switches on.
// - Captured position is kept until power loss; nothing else clears it.
// - Armed latch cancels at program end, mode change, forced stop, alarm, servo-off.
// - A temporary stop alone leaves the armed latch in effect.
// - Captured position is readable over the communication interface.
// - Speed, time, travel, dwell and program-repeat may take a register's content.
// - Register contents are lost at power-off; position registers may be saved.
// - Each general purpose register accepts the full range of its command.
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH

// Bus geometry
`define WB_AW          8
`define WB_DW          32
`define WB_LANES       4
// Register offsets
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_PULSES     8'h08
`define REG_LATCH_POS  8'h0C
`define REG_STEP       8'h10
`define REG_GPR_FIRST  8'h20
`define REG_GPR_LAST   8'h3C
// Control bits
`define CTRL_START     0
`define CTRL_STOP      1
`define CTRL_SAVE      2
// Status bits
`define ST_RUN         0
`define ST_WAIT_COUNT  1
`define ST_WAIT_LATCH  2
`define ST_ARMED       3
`define ST_CAPTURED    4
`define ST_IN_LOOP     5
`define ST_WAIT_CMD    6
// Instruction word fields
`define OP_HI          31
`define OP_LO          28
`define IND_BIT        27
`define SEL_HI         26
`define SEL_LO         24
`define IMM_HI         23
// Opcodes; 8 and above go to the motion executor
`define OP_STOP        4'h0
`define OP_COUNT       4'h1
`define OP_FOR         4'h2
`define OP_NEXT        4'h3
`define OP_PROGRAM_REPEAT_CMD       4'h4
`define OP_LATCH       4'h5
`define OP_MOTION_MIN  4'h8
// Sizes
`define STEP_W         8
`define GPR_CNT        8
`define GPR_SEL_W      3
`define POS_REG_CNT    4

`endif

// File: rtl/seq_pkg.sv
/*
 Types shared by the sequencer and its pulse accumulator.
 Assumes seq_regs.svh is on the include path.
*/
`include "seq_regs.svh"

package seq_pkg;

   typedef enum logic [2:0] {
      S_IDLE,
      S_FETCH,
      S_DECODE,
      S_CMD,
      S_WAIT_COUNT,
      S_WAIT_LATCH
   } seq_state_type;

   typedef logic [`WB_DW-1:0] word_type;

   typedef struct packed {
      logic     in_prev;
      word_type total;
   } pulse_state_type;

   typedef struct packed {
      seq_state_type                 state;
      logic [`STEP_W-1:0]            pc;
      logic [`STEP_W-1:0]            loop_start;
      word_type                      loop_cnt;
      logic                          loop_inf;
      logic                          in_loop;
      word_type                      program_repeat_cmd_cnt;
      logic                          program_repeat_cmd_inf;
      logic                          first_pass;
      word_type                      value;
      logic                          armed;
      logic                          captured;
      logic                          latch_prev;
      word_type                      latch_pos;
      logic [`GPR_CNT-1:0][`WB_DW-1:0] gpr;
      logic                          ack;
      word_type                      dat;
      logic                          pulse_clr;
      logic                          nv_save;
      logic [`OP_HI-`OP_LO:0]        cmd_op;
      word_type                      cmd_value;
   } seq_state_reg_type;

endpackage : seq_pkg

// File: rtl/pulse_accumulator.sv
/*
 Accumulates pulses from the manual pulse generator, up or down by direction.
 Assumes pulse and direction inputs are synchronous to clk_i.
*/
`timescale 1ns/10ps
`include "seq_regs.svh"

module pulse_accumulator
   import seq_pkg::*;
(
   // Clock and reset
   input  wire logic     clk_i,
   input  wire logic     rst_i,
   input  wire logic     ce_i,
   // Generator side
   input  wire logic     pulse_i,
   input  wire logic     dir_down_i,
   // Sequencer side
   input  wire logic     clear_i,
   output word_type      total_o
);

   pulse_state_type s_q;
   pulse_state_type s_d;

   always_comb begin
      s_d         = s_q;
      s_d.in_prev = pulse_i;
      // Clear wins: a pulse in the clearing cycle belongs to the old total
      if (clear_i) begin
         s_d.total = '0;
      end else if (pulse_i && !s_q.in_prev) begin
         s_d.total = dir_down_i ? s_q.total - 1'b1 : s_q.total + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign total_o = s_q.total;

endmodule : pulse_accumulator

// File: rtl/positioning_program_flow_sequencer.sv
/*
 Program flow sequencer: pulse wait, step loops, program repeat, position latch and
 indirect settings from general purpose registers, with a classic Wishbone slave.
 Assumes a program store that returns the word one cycle after the step address, a
 motion executor that acknowledges each passed-on command with a one-cycle done pulse,
 and all inputs synchronous to clk_i.
*/
`timescale 1ns/10ps
`include "seq_regs.svh"

module positioning_program_flow_sequencer
   import seq_pkg::*;
(
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         ce_i,
   // Wishbone slave
   input  wire logic                         cyc_i,
   input  wire logic                         stb_i,
   input  wire logic                         we_i,
   input  wire logic [`WB_AW-1:0]            adr_i,
   input  wire logic [`WB_LANES-1:0]         sel_i,
   input  wire logic [`WB_DW-1:0]            dat_i,
   output      logic [`WB_DW-1:0]            dat_o,
   output      logic                         ack_o,
   // Program store
   output      logic [`STEP_W-1:0]           prog_addr_o,
   input  wire logic [`WB_DW-1:0]            prog_data_i,
   // Motion executor
   output      logic                         cmd_valid_o,
   output      logic [`OP_HI-`OP_LO:0]       cmd_op_o,
   output      logic [`WB_DW-1:0]            cmd_value_o,
   input  wire logic                         cmd_done_i,
   // Machine state
   input  wire logic [`WB_DW-1:0]            position_i,
   input  wire logic                         position_latch_input_i,
   input  wire logic                         mpg_pulse_i,
   input  wire logic                         mpg_dir_down_i,
   input  wire logic                         temp_stop_i,
   input  wire logic                         mode_change_i,
   input  wire logic                         forced_stop_i,
   input  wire logic                         alarm_i,
   input  wire logic                         servo_off_i,
   // Status and nonvolatile save
   output      logic                         running_o,
   output      logic [`POS_REG_CNT-1:0][`WB_DW-1:0] position_value_regs_o,
   output      logic                         nv_save_o
);

   seq_state_reg_type q;
   seq_state_reg_type d;
   word_type          pulse_total;

   pulse_accumulator u_pulses (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .pulse_i    (mpg_pulse_i),
      .dir_down_i (mpg_dir_down_i),
      .clear_i    (q.pulse_clr),
      .total_o    (pulse_total)
   );

   function automatic word_type merge_lanes(input word_type old_w, input word_type new_w,
                                            input logic [`WB_LANES-1:0] lanes);
      word_type r;
      r = old_w;
      for (int i = 0; i < `WB_LANES; i++) begin
         if (lanes[i]) begin
            r[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_lanes

   always_comb begin
      logic                     req;
      logic                     wr;
      logic                     sw_start;
      logic                     sw_stop;
      logic                     abort;
      logic                     rise;
      logic                     gpr_hit;
      logic [`GPR_SEL_W-1:0]    gidx;
      logic [`WB_AW-1:0]        goff;
      word_type                 status;
      word_type                 inst;
      logic [`OP_HI-`OP_LO:0]   op;
      word_type                 val;
      logic                     may_ind;

      d           = q;
      d.ack       = 1'b0;
      d.pulse_clr = 1'b0;
      d.nv_save   = 1'b0;

      req      = cyc_i && stb_i;
      wr       = req && q.ack && we_i;
      goff     = adr_i - `REG_GPR_FIRST;
      gidx     = goff[`GPR_SEL_W+1:2];
      gpr_hit  = (adr_i >= `REG_GPR_FIRST) && (adr_i <= `REG_GPR_LAST);
      sw_start = wr && adr_i == `REG_CTRL && sel_i[0] && dat_i[`CTRL_START];
      sw_stop  = wr && adr_i == `REG_CTRL && sel_i[0] && dat_i[`CTRL_STOP];

      status                 = '0;
      status[`ST_RUN]        = q.state != S_IDLE;
      status[`ST_WAIT_COUNT] = q.state == S_WAIT_COUNT;
      status[`ST_WAIT_LATCH] = q.state == S_WAIT_LATCH;
      status[`ST_ARMED]      = q.armed;
      status[`ST_CAPTURED]   = q.captured;
      status[`ST_IN_LOOP]    = q.in_loop;
      status[`ST_WAIT_CMD]   = q.state == S_CMD;

      // Answer one cycle after the request; write lands on the acknowledged edge
      if (req && !q.ack) begin
         d.ack = 1'b1;
         unique case (1'b1)
            adr_i == `REG_STATUS:    d.dat = status;
            adr_i == `REG_PULSES:    d.dat = pulse_total;
            adr_i == `REG_LATCH_POS: d.dat = q.latch_pos;
            adr_i == `REG_STEP:      d.dat = word_type'(q.pc);
            gpr_hit:                 d.dat = q.gpr[gidx];
            default:                 d.dat = '0;
         endcase
      end
      // Writes while running are dropped so a step never sees a half-changed setting
      if (wr && gpr_hit && q.state == S_IDLE) begin
         d.gpr[gidx] = merge_lanes(q.gpr[gidx], dat_i, sel_i);
      end
      if (wr && adr_i == `REG_CTRL && sel_i[0] && dat_i[`CTRL_SAVE]) begin
         d.nv_save = 1'b1;
      end

      // Position latch
      rise         = position_latch_input_i && !q.latch_prev;
      d.latch_prev = position_latch_input_i;
      if (q.armed && rise) begin
         d.latch_pos = position_i;
         d.captured  = 1'b1;
         d.armed     = 1'b0;
      end

      // Decode of the word fetched for the current step
      inst    = prog_data_i;
      op      = inst[`OP_HI:`OP_LO];
      may_ind = (op == `OP_PROGRAM_REPEAT_CMD) || (op >= `OP_MOTION_MIN);
      if (may_ind && inst[`IND_BIT]) begin
         val = q.gpr[inst[`SEL_HI:`SEL_LO]];
      end else begin
         val = word_type'(signed'(inst[`IMM_HI:0]));
      end

      unique case (q.state)
         S_IDLE: begin
            if (sw_start) begin
               d.state      = S_FETCH;
               d.pc         = '0;
               d.program_repeat_cmd_cnt  = word_type'(1);
               d.program_repeat_cmd_inf  = 1'b0;
               d.first_pass = 1'b1;
               d.in_loop    = 1'b0;
            end
         end
         S_FETCH: begin
            // Temporary stop only holds the step; the latch stays armed
            if (!temp_stop_i) begin
               d.state = S_DECODE;
            end
         end
         S_DECODE: begin
            d.value = val;
            d.state = S_FETCH;
            d.pc    = q.pc + 1'b1;
            unique case (op)
               `OP_STOP: begin
                  if (q.program_repeat_cmd_inf || q.program_repeat_cmd_cnt > word_type'(1)) begin
                     if (!q.program_repeat_cmd_inf) begin
                        d.program_repeat_cmd_cnt = q.program_repeat_cmd_cnt - 1'b1;
                     end
                     d.pc         = '0;
                     d.first_pass = 1'b0;
                     d.in_loop    = 1'b0;
                  end else begin
                     d.state = S_IDLE;
                     d.armed = 1'b0;
                  end
               end
               `OP_PROGRAM_REPEAT_CMD: begin
                  if (q.pc == '0 && q.first_pass) begin
                     d.program_repeat_cmd_cnt = val;
                     d.program_repeat_cmd_inf = val == '0;
                  end
               end
               `OP_FOR: begin
                  // A second loop-open simply restarts the loop; nesting is unsupported
                  d.loop_start = q.pc + 1'b1;
                  d.loop_cnt   = val;
                  d.loop_inf   = val == '0;
                  d.in_loop    = 1'b1;
               end
               `OP_NEXT: begin
                  if (q.in_loop && (q.loop_inf || q.loop_cnt > word_type'(1))) begin
                     if (!q.loop_inf) begin
                        d.loop_cnt = q.loop_cnt - 1'b1;
                     end
                     d.pc = q.loop_start;
                  end else begin
                     d.in_loop = 1'b0;
                  end
               end
               `OP_COUNT: begin
                  if (val == '0) begin
                     d.pulse_clr = 1'b1;
                  end else begin
                     d.pc    = q.pc;
                     d.state = S_WAIT_COUNT;
                  end
               end
               `OP_LATCH: begin
                  d.pc    = q.pc;
                  d.armed = 1'b1;
                  d.state = S_WAIT_LATCH;
               end
               default: begin
                  if (op >= `OP_MOTION_MIN) begin
                     d.pc        = q.pc;
                     d.cmd_op    = op;
                     d.cmd_value = val;
                     d.state     = S_CMD;
                  end
               end
            endcase
         end
         S_CMD: begin
            if (cmd_done_i) begin
               d.pc    = q.pc + 1'b1;
               d.state = S_FETCH;
            end
         end
         S_WAIT_COUNT: begin
            // Strictly greater: reaching the setting is not enough
            if ($signed(pulse_total) > $signed(q.value)) begin
               d.pc    = q.pc + 1'b1;
               d.state = S_FETCH;
            end
         end
         S_WAIT_LATCH: begin
            if (q.armed && rise) begin
               d.pc    = q.pc + 1'b1;
               d.state = S_FETCH;
            end
         end
      endcase

      abort = sw_stop || mode_change_i || forced_stop_i || alarm_i || servo_off_i;
      if (abort) begin
         d.state   = S_IDLE;
         d.armed   = 1'b0;
         d.in_loop = 1'b0;
      end
   end

   // Reset stands for power-on: registers and latched position start empty
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q       <= '0;
         q.state <= S_IDLE;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign ack_o                 = q.ack;
   assign dat_o                 = q.dat;
   assign prog_addr_o           = q.pc;
   assign cmd_valid_o           = q.state == S_CMD;
   assign cmd_op_o              = q.cmd_op;
   assign cmd_value_o           = q.cmd_value;
   assign running_o             = q.state != S_IDLE;
   assign position_value_regs_o = q.gpr[`POS_REG_CNT-1:0];
   assign nv_save_o             = q.nv_save;

endmodule : positioning_program_flow_sequencer

// File: dv/positioning_program_flow_sequencer_checker.sv
/*
 Port checker for the flow sequencer, bound to it at the foot of this file.
 Assumes seq_regs.svh on the include path and one clock domain.
*/
`timescale 1ns/10ps
`include "seq_regs.svh"

module seq_flow_checker
   import seq_pkg::*;
(
   // Clock, reset and bus
   input wire logic                                 clk_i,
   input wire logic                                 rst_i,
   input wire logic                                 ce_i,
   input wire logic                                 cyc_i,
   input wire logic                                 stb_i,
   input wire logic                                 we_i,
   input wire logic [`WB_AW-1:0]                    adr_i,
   input wire logic [`WB_DW-1:0]                    dat_o,
   input wire logic                                 ack_o,
   // Sequencer side
   input wire logic [`STEP_W-1:0]                   prog_addr_o,
   input wire logic                                 cmd_valid_o,
   input wire logic [`OP_HI-`OP_LO:0]               cmd_op_o,
   input wire logic [`WB_DW-1:0]                    cmd_value_o,
   input wire logic                                 cmd_done_i,
   input wire logic                                 mode_change_i,
   input wire logic                                 forced_stop_i,
   input wire logic                                 alarm_i,
   input wire logic                                 servo_off_i,
   input wire logic                                 running_o,
   input wire logic [`POS_REG_CNT-1:0][`WB_DW-1:0]  position_value_regs_o
);
   logic abort;
   assign abort = mode_change_i | forced_stop_i | alarm_i | servo_off_i;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_req;
      cyc_i && stb_i && !ack_o && ce_i;
   endsequence
   // Abort or a stop write may drop a waiting command, so both are left out here
   sequence s_cmd_wait;
      cmd_valid_o && !cmd_done_i && !abort && ce_i && !(ack_o && we_i && adr_i == `REG_CTRL);
   endsequence
   a_ack_answer: assert property (s_req |=> ack_o)
      else $error("no ack one cycle after request");
   a_ack_single: assert property (ack_o && ce_i |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_unasked: assert property (!(cyc_i && stb_i) && ce_i |=> !ack_o)
      else $error("ack without request");
   a_ctrl_reads_zero: assert property (cyc_i && stb_i && !ack_o && !we_i && adr_i == `REG_CTRL && ce_i |=> dat_o == '0)
      else $error("control read not zero");
   a_cmd_holds: assert property (s_cmd_wait |=> cmd_valid_o && $stable(cmd_op_o) && $stable(cmd_value_o))
      else $error("command dropped or changed before done");
   a_cmd_release: assert property (cmd_valid_o && cmd_done_i && ce_i |=> !cmd_valid_o)
      else $error("command still valid after done");
   a_abort_idles: assert property (abort && ce_i |=> !running_o && !cmd_valid_o)
      else $error("abort did not stop the program");
   a_regs_frozen: assert property (running_o |=> $stable(position_value_regs_o))
      else $error("register changed while running");
   a_start_step_zero: assert property ($rose(running_o) |-> prog_addr_o == '0)
      else $error("program did not start at step zero");
   a_idle_no_cmd: assert property (!running_o |-> !cmd_valid_o)
      else $error("command issued while idle");
endmodule : seq_flow_checker

bind positioning_program_flow_sequencer seq_flow_checker u_checker (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .prog_addr_o(prog_addr_o), .cmd_valid_o(cmd_valid_o),
   .cmd_op_o(cmd_op_o), .cmd_value_o(cmd_value_o), .cmd_done_i(cmd_done_i), .mode_change_i(mode_change_i),
   .forced_stop_i(forced_stop_i), .alarm_i(alarm_i), .servo_off_i(servo_off_i), .running_o(running_o),
   .position_value_regs_o(position_value_regs_o)
);

// File: dv/mpg_latch_model.sv
/*
 Pulse generator and latch input model for the machine side.
 Assumes the caller runs its tasks from a process synchronous to clk_i.
*/
`timescale 1ns/10ps

module mpg_latch_model (
   // Clock
   input  wire logic        clk_i,
   // Toward the sequencer
   output      logic        pulse_o,
   output      logic        dir_down_o,
   output      logic        latch_o,
   output      logic [31:0] position_o
);
   logic [31:0] exp_pos;
   initial begin
      pulse_o = 1'b0;
      dir_down_o = 1'b0;
      latch_o = 1'b0;
      position_o = 32'h0000_1000;
   end
   // Position keeps moving, so a capture on the wrong edge shows
   always @(posedge clk_i) position_o <= position_o + 32'h0000_0003;
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk_i);
         pulse_o <= 1'b1;
         @(posedge clk_i);
         pulse_o <= 1'b0;
      end
   endtask : pulses
   task automatic latch_on();
      @(posedge clk_i);
      latch_o <= 1'b1;
      exp_pos = position_o + 32'h0000_0003;
      repeat (2) @(posedge clk_i);
      latch_o <= 1'b0;
   endtask : latch_on
endmodule : mpg_latch_model

// File: dv/test_positioning_program_flow_sequencer.sv
/*
 Self-checking bench: Wishbone tasks, program store and motion executor.
 Assumes the checker is bound and the pulse and latch model drives the machine side.
*/
`timescale 1ns/10ps
`include "seq_regs.svh"

module test_positioning_program_flow_sequencer
   import seq_pkg::*;
;
   logic                  clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic                  temp_stop_i = 1'b0, cmd_done_i = 1'b0, ack_o, cmd_valid_o, running_o, pulse, dn, latch;
   logic [3:0]            abort_v = 4'h0, sel_i = 4'hF, cmd_op_o;
   logic [`WB_AW-1:0]     adr_i = 8'h00;
   logic [`STEP_W-1:0]    prog_addr_o;
   word_type              dat_i = 32'h0, prog_data_i = 32'h0, dat_o, cmd_value_o, position, last_val, d, cap;
   word_type              prog_mem [16];
   logic [3:0][31:0]      pos_regs;
   int                    n_mismatch = 0, n_tests = 0, n_cmd = 0;

   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) prog_data_i <= prog_mem[prog_addr_o[3:0]];
   // Executor answers a cycle late, so the command must stand meanwhile
   always @(posedge clk_i) begin
      cmd_done_i <= cmd_valid_o && !cmd_done_i;
      if (cmd_valid_o && cmd_done_i) begin
         n_cmd <= n_cmd + 1;
         last_val <= cmd_value_o;
      end
   end

   positioning_program_flow_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i), .cmd_valid_o(cmd_valid_o), .cmd_op_o(cmd_op_o),
      .cmd_value_o(cmd_value_o), .cmd_done_i(cmd_done_i), .position_i(position), .position_latch_input_i(latch),
      .mpg_pulse_i(pulse), .mpg_dir_down_i(dn), .temp_stop_i(temp_stop_i), .mode_change_i(abort_v[0]),
      .forced_stop_i(abort_v[1]), .alarm_i(abort_v[2]), .servo_off_i(abort_v[3]), .running_o(running_o),
      .position_value_regs_o(pos_regs), .nv_save_o());
   mpg_latch_model mdl (.clk_i(clk_i), .pulse_o(pulse), .dir_down_o(dn), .latch_o(latch), .position_o(position));

   task automatic give_verdict();
      $display("counts: %0d comparisons, %0d mismatches", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input word_type exp, input word_type got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic timeout(input string what);
      n_mismatch++;
      $display("mismatch %s timed out", what);
      give_verdict();
   endtask : timeout
   task automatic wb(input logic [7:0] a, input logic w, input word_type wd);
      int n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) timeout("ack");
      d = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : wb
   task automatic rd_chk(input logic [7:0] a, input word_type exp, input string what);
      wb(a, 1'b0, 32'h0);
      check(what, exp, d);
   endtask : rd_chk
   task automatic wait_idle();
      int n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (running_o !== 1'b0 && n < 3000);
      if (running_o !== 1'b0) timeout("idle");
   endtask : wait_idle
   function automatic word_type ins(input logic [3:0] op, input logic [3:0] sel, input logic [23:0] imm);
      return {op, sel, imm};
   endfunction : ins
   task automatic load(input word_type w0, input word_type w1, input word_type w2);
      prog_mem = '{default: 32'h0};
      prog_mem[0] = w0;
      prog_mem[1] = w1;
      prog_mem[2] = w2;
   endtask : load
   task automatic run(input int exp_n, input string what);
      n_cmd = 0;
      wb(`REG_CTRL, 1'b1, 32'h1);
      wait_idle();
      check(what, 32'(exp_n), 32'(n_cmd));
   endtask : run
   // Endless program: must still run after six commands, then stop on request
   task automatic endless(input string what);
      int n = 0;
      n_cmd = 0;
      wb(`REG_CTRL, 1'b1, 32'h1);
      while (n_cmd < 6 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      if (n_cmd < 6) timeout(what);
      check(what, 32'h1, 32'(running_o));
      wb(`REG_CTRL, 1'b1, 32'h2);
      @(posedge clk_i);
      check("stop", 32'h0, 32'(running_o));
   endtask : endless

   initial begin
      load(32'h0, 32'h0, 32'h0);
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(`REG_STATUS, 32'h0, "status");
      rd_chk(`REG_LATCH_POS, 32'h0, "latch");
      rd_chk(8'h40, 32'h0, "unmapped");
      rd_chk(`REG_CTRL, 32'h0, "ctrl");
      wb(8'h20, 1'b1, 32'hDEAD_BEEF);
      wb(8'h30, 1'b1, 32'h0000_0003);
      wb(8'h3C, 1'b1, 32'hFFFF_FFFF);
      rd_chk(8'h3C, 32'hFFFF_FFFF, "gpr full");
      check("pos reg", 32'hDEAD_BEEF, pos_regs[0]);
      $display("test registers done");
      load(ins(4'h1, 4'h0, 24'd5), ins(4'h1, 4'h0, 24'd0), 32'h0);
      wb(`REG_CTRL, 1'b1, 32'h1);
      mdl.pulses(5);
      rd_chk(`REG_PULSES, 32'h5, "pulses");
      rd_chk(`REG_STATUS, 32'h0000_0003, "waits at equal");
      mdl.pulses(1);
      wait_idle();
      rd_chk(`REG_PULSES, 32'h0, "cleared");
      $display("test pulse wait done");
      for (int k = 1; k <= 3; k += 2) begin
         load(ins(4'h2, 4'h0, 24'(k)), ins(4'h8, 4'h0, 24'hFFFFF9), ins(4'h3, 4'h0, 24'h0));
         run(k, "loop count");
      end
      check("value", 32'hFFFF_FFF9, last_val);
      load(ins(4'h2, 4'h0, 24'h0), ins(4'h8, 4'h0, 24'h1), ins(4'h3, 4'h0, 24'h0));
      endless("endless loop");
      $display("test loops done");
      load(ins(4'h4, 4'h0, 24'd2), ins(4'h9, 4'h0, 24'h1), 32'h0);
      run(2, "repeat 2");
      load(ins(4'h9, 4'h0, 24'h1), 32'h0, 32'h0);
      run(1, "no repeat");
      load(ins(4'h4, 4'hC, 24'h0), ins(4'h9, 4'h8, 24'h0), 32'h0);
      run(3, "indirect repeat");
      check("indirect value", 32'hDEAD_BEEF, last_val);
      load(ins(4'h4, 4'h0, 24'h0), ins(4'h9, 4'h0, 24'h1), 32'h0);
      endless("endless repeat");
      $display("test repeats done");
      load(ins(4'h5, 4'h0, 24'h0), 32'h0, 32'h0);
      wb(`REG_CTRL, 1'b1, 32'h1);
      rd_chk(`REG_STEP, 32'h0, "held step");
      rd_chk(`REG_STATUS, 32'h0000_000D, "armed");
      temp_stop_i <= 1'b1;
      rd_chk(`REG_STATUS, 32'h0000_000D, "armed in stop");
      temp_stop_i <= 1'b0;
      mdl.latch_on();
      wait_idle();
      rd_chk(`REG_LATCH_POS, mdl.exp_pos, "captured");
      rd_chk(`REG_STATUS, 32'h0000_0010, "disarmed at end");
      cap = mdl.exp_pos;
      for (int k = 0; k < 4; k++) begin
         wb(`REG_CTRL, 1'b1, 32'h1);
         // Let the latch command arm before aborting
         repeat (2) @(posedge clk_i);
         abort_v[k] <= 1'b1;
         repeat (2) @(posedge clk_i);
         abort_v[k] <= 1'b0;
         rd_chk(`REG_STATUS, 32'h0000_0010, "abort disarms");
         mdl.latch_on();
         rd_chk(`REG_LATCH_POS, cap, "kept");
      end
      $display("test latch done");
      give_verdict();
   end
endmodule : test_positioning_program_flow_sequencer
